//--- lspc_pkg.sv
// How it works
// - On enable rising, start in 1x mode regulating from feedback_sense.
// - In 1x, feedback low on 33 consecutive pump ticks selects 2x.
// - 2x holds until enable toggles, select falls, power cycles, thermal, strobe timeout.
// - Select low picks fixed 50mV torch target; high picks resistor target.
// - Strobe mode times on period, shuts down after about 1.6 seconds.
// - After timeout, strobe waits until enable or select goes low.
// - Output above 5.5V stops all switches; resumes when it falls back.
// - Averaged current above twice programmed stops the output switches.
// - Switching and dropout timing use the pump tick (25MHz/13, near 2MHz); soft start and strobe count clk_sys.
// - Soft start reaches 90% regulation typically 250us, at most 500us.
// - Enable low holds shutdown with switching stopped.
package lspc_pkg;
    localparam int unsigned CLK_HZ         = 25000000;
    localparam int unsigned PUMP_HZ        = 2000000;
    // Nearest whole divider; 25 MHz is not a multiple of 2 MHz
    localparam int unsigned PUMP_DIV       = (CLK_HZ + PUMP_HZ / 2) / PUMP_HZ;
    localparam int unsigned DROPOUT_TICKS  = 32;
    localparam int unsigned STROBE_LIMIT_MS = 1600;
    localparam int unsigned STROBE_CYCLES  = CLK_HZ / 1000 * STROBE_LIMIT_MS;
    localparam int unsigned SOFT_START_US  = 250;
    localparam int unsigned SOFT_START_CYC = CLK_HZ / 1000000 * SOFT_START_US;
    localparam int unsigned DIV_W          = 4;
    localparam int unsigned DROP_W         = 6;
    localparam int unsigned SS_W           = 13;
    localparam int unsigned TMR_W          = 26;

    typedef enum logic [1:0] {
        LSPC_OFF  = 2'b00,
        LSPC_SOFT = 2'b01,
        LSPC_X1   = 2'b11,
        LSPC_X2   = 2'b10
    } lspc_mode_t;

    typedef struct packed {
        logic pump_enable;
        logic pump_double;
        logic strobe_target;
        logic soft_start;
        logic strobe_timed_out;
        logic pump_tick;
    } lspc_out_t;

    typedef struct packed {
        logic low_feedback;
        logic over_voltage;
        logic over_current;
        logic thermal_trip;
    } lspc_sense_t;
endpackage

//--- lspc_ctrl.sv
module lspc_ctrl
    import lspc_pkg::*;
#(
    parameter int unsigned STROBE_CYC = STROBE_CYCLES,
    parameter int unsigned SS_CYC     = SOFT_START_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        enable_in,
    input  wire logic        strobe_sel,
    input  wire lspc_sense_t sense,
    output lspc_out_t        ctl
);
    typedef struct packed {
        lspc_mode_t        mode;
        logic [DIV_W-1:0]  div;
        logic              tick;
        logic [DROP_W-1:0] drop;
        logic [SS_W-1:0]   ss;
        logic [TMR_W-1:0]  tmr;
        logic              timed_out;
        logic              en_prev;
        logic              sel_prev;
        logic              gate;
    } lspc_st_t;

    lspc_st_t s_q;
    lspc_st_t s_d;
    logic     restart;
    logic     fault;

    always_comb begin
        s_d = s_q;
        // Select fall drops back to 1x; enable edges also restart, but enable low forces shutdown
        restart = (enable_in != s_q.en_prev) || (s_q.sel_prev && !strobe_sel);
        // Overvoltage and overcurrent gate switches only, mode kept
        fault = sense.over_voltage || sense.over_current;
        s_d.en_prev = enable_in;
        s_d.sel_prev = strobe_sel;
        s_d.tick = 1'b0;
        if (s_q.div == DIV_W'(PUMP_DIV - 1)) begin
            s_d.div = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 1'b1;
        end
        // Re-arm needs enable or select low
        if (!enable_in || !strobe_sel) begin
            s_d.timed_out = 1'b0;
        end
        if (strobe_sel && s_q.mode != LSPC_OFF && !s_q.timed_out) begin
            if (s_q.tmr == TMR_W'(STROBE_CYC - 1)) begin
                s_d.timed_out = 1'b1;
            end else begin
                s_d.tmr = s_q.tmr + 1'b1;
            end
        end
        if (!strobe_sel) begin
            s_d.tmr = '0;
        end
        case (s_q.mode)
            LSPC_OFF: begin
                s_d.ss = '0;
                s_d.drop = '0;
                s_d.tmr = '0;
                if (enable_in && !sense.thermal_trip
                    && !(strobe_sel && s_q.timed_out)) begin
                    s_d.mode = LSPC_SOFT;
                end
            end
            LSPC_SOFT: begin
                if (s_q.ss == SS_W'(SS_CYC - 1)) begin
                    s_d.mode = LSPC_X1;
                end else begin
                    s_d.ss = s_q.ss + 1'b1;
                end
            end
            LSPC_X1: begin
                if (s_q.tick) begin
                    if (!sense.low_feedback) begin
                        s_d.drop = '0;
                    end else if (s_q.drop == DROP_W'(DROPOUT_TICKS)) begin
                        s_d.mode = LSPC_X2;
                    end else begin
                        s_d.drop = s_q.drop + 1'b1;
                    end
                end
                if (restart) begin
                    s_d.drop = '0;
                end
            end
            LSPC_X2: begin
                if (restart) begin
                    s_d.mode = LSPC_X1;
                    s_d.drop = '0;
                end
            end
            default: s_d.mode = LSPC_OFF;
        endcase
        // Shutdown paths win over everything
        if (!enable_in || sense.thermal_trip
            || (strobe_sel && s_d.timed_out)) begin
            s_d.mode = LSPC_OFF;
        end
        s_d.gate = (s_d.mode != LSPC_OFF) && !fault;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ctl.pump_enable      = s_q.gate;
    assign ctl.pump_double      = s_q.mode == LSPC_X2;
    assign ctl.strobe_target    = strobe_sel;
    assign ctl.soft_start       = s_q.mode == LSPC_SOFT;
    assign ctl.strobe_timed_out = s_q.timed_out;
    assign ctl.pump_tick        = s_q.tick;

    a_shutdown_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !enable_in |=> !ctl.pump_enable)
        else $error("switching while disabled");
    a_ovp_gate: assert property (@(posedge clk_sys) disable iff (rst)
        sense.over_voltage |=> !ctl.pump_enable)
        else $error("switching during overvoltage");
    a_ocp_gate: assert property (@(posedge clk_sys) disable iff (rst)
        sense.over_current |=> !ctl.pump_enable)
        else $error("switching during overcurrent");
    a_thermal_off: assert property (@(posedge clk_sys) disable iff (rst)
        sense.thermal_trip |=> !ctl.pump_enable && !ctl.pump_double)
        else $error("thermal trip ignored");
    a_start_soft: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.mode == LSPC_OFF && s_d.mode != LSPC_OFF
        |=> ctl.soft_start && !ctl.pump_double)
        else $error("start not in 1x soft start");
    a_x2_hold: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.pump_double && enable_in && $stable(enable_in)
        && !($past(strobe_sel) && !strobe_sel) && !sense.thermal_trip
        && !(strobe_sel && s_d.timed_out) |=> ctl.pump_double)
        else $error("2x left without cause");
    a_x2_entry: assert property (@(posedge clk_sys) disable iff (rst)
        !ctl.pump_double ##1 ctl.pump_double
        |-> $past(s_q.drop) == DROP_W'(DROPOUT_TICKS))
        else $error("2x entered early");
    a_tick_period: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.pump_tick |=> !ctl.pump_tick)
        else $error("tick too frequent");
    a_timeout_off: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.strobe_timed_out && strobe_sel |-> !ctl.pump_enable)
        else $error("strobe restarted after timeout");
    a_target_sel: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.strobe_target == strobe_sel)
        else $error("target select wrong");

    // Last low tick of a dropout run in 1x
    sequence s_dropout_done;
        s_q.mode == LSPC_X1 && s_q.tick && sense.low_feedback
        && s_q.drop == DROP_W'(DROPOUT_TICKS);
    endsequence

    // Conditions under which no shutdown path fires this cycle
    sequence s_keep_running;
        enable_in && !sense.thermal_trip && !(strobe_sel && s_d.timed_out);
    endsequence

    a_dropout_escalate: assert property (@(posedge clk_sys) disable iff (rst)
        s_dropout_done ##0 s_keep_running |=> ctl.pump_double)
        else $error("dropout did not select 2x");
    a_x2_from_x1: assert property (@(posedge clk_sys) disable iff (rst)
        !ctl.pump_double ##1 ctl.pump_double
        |-> $past(s_q.mode) == LSPC_X1)
        else $error("2x entered from wrong mode");
    a_drop_clear: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.mode == LSPC_X1 && s_q.tick && !sense.low_feedback
        |=> s_q.drop == '0)
        else $error("dropout count not cleared");
    a_x2_sel_fall: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.pump_double && $fell(strobe_sel) |=> !ctl.pump_double)
        else $error("2x kept after select fall");
    a_soft_origin: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(ctl.soft_start) |-> $past(s_q.mode) == LSPC_OFF)
        else $error("soft start not from shutdown");
    a_soft_to_x1: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.soft_start && s_q.ss == SS_W'(SS_CYC - 1) ##0 s_keep_running
        |=> s_q.mode == LSPC_X1)
        else $error("soft start did not end in 1x");
    a_soft_count: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.soft_start && s_q.ss != SS_W'(SS_CYC - 1) ##0 s_keep_running
        |=> ctl.soft_start
        && s_q.ss == SS_W'($past(s_q.ss) + 1'b1))
        else $error("soft start count stalled");
    a_timer_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !strobe_sel |=> s_q.tmr == '0)
        else $error("strobe timer runs in torch mode");
    a_off_timer: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.mode == LSPC_OFF |=> s_q.tmr == '0)
        else $error("strobe timer runs in shutdown");
    a_timeout_set: assert property (@(posedge clk_sys) disable iff (rst)
        strobe_sel && s_q.mode != LSPC_OFF && !s_q.timed_out
        && s_q.tmr == TMR_W'(STROBE_CYC - 1)
        |=> ctl.strobe_timed_out && !ctl.pump_enable)
        else $error("strobe limit not enforced");
    a_rearm_sel: assert property (@(posedge clk_sys) disable iff (rst)
        !strobe_sel |=> !ctl.strobe_timed_out)
        else $error("timeout not re-armed");
    a_fault_resume: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.mode == LSPC_X1 || s_q.mode == LSPC_X2)
        && !sense.over_voltage && !sense.over_current ##0 s_keep_running
        |=> ctl.pump_enable)
        else $error("switching not resumed");
    a_tick_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.pump_tick |=> !ctl.pump_tick [*8])
        else $error("tick spacing short");
    a_tick_repeat: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.pump_tick |-> ##13 ctl.pump_tick)
        else $error("tick period wrong");
endmodule // lspc_ctrl

//--- lspc_host.sv
module lspc_host
    import lspc_pkg::*;
(
    input  wire logic en_req,
    input  wire logic sel_req,
    output logic      enable_in,
    output logic      strobe_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Levels follow the bench, which only moves them at falling edges
    assign enable_in  = en_req;
    // Re-arm is a low then high level on either pin
    assign strobe_sel = sel_req;
endmodule // lspc_host

//--- tb_top.sv
module tb_top
    import lspc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SC = 200;
    localparam int unsigned SS = 8;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        en_req = 1'b0;
    logic        sel_req = 1'b0;
    logic        enable_in;
    logic        strobe_sel;
    lspc_sense_t sense = '0;
    lspc_out_t   ctl;
    logic [16:0] s = 17'h13ea6;
    int          errors = 0;
    int          checks = 0;
    int          n;
    lspc_host host (.en_req(en_req), .sel_req(sel_req),
        .enable_in(enable_in), .strobe_sel(strobe_sel));
    lspc_ctrl #(.STROBE_CYC(SC), .SS_CYC(SS)) DUT (.clk_sys(clk_sys),
        .rst(rst), .enable_in(enable_in), .strobe_sel(strobe_sel),
        .sense(sense), .ctl(ctl));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction
    task automatic step(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    task automatic chk(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk_sys);
        errors++;
        final_report();
    end
    initial begin
        step(2);
        rst = 1'b0;
        chk(ctl.pump_enable | ctl.soft_start | ctl.pump_double, 1'b0);
        en_req = 1'b1;
        step(1);
        chk(ctl.soft_start & ctl.pump_enable, 1'b1);
        step(SS + 1);
        chk(ctl.soft_start | ctl.pump_double, 1'b0);
        chk(ctl.strobe_target, 1'b0);
        n = 0;
        while (ctl.pump_tick !== 1'b1 && n < 40) begin step(1); n++; end
        n = 0;
        step(1);
        while (ctl.pump_tick !== 1'b1 && n < 40) begin step(1); n++; end
        chk(n + 1 == PUMP_DIV, 1'b1);
        // Maximal sequence keeps any run of ones far below the dropout span
        repeat (600) begin
            s = lfsr(s);
            sense.low_feedback = s[0];
            step(1);
        end
        chk(ctl.pump_double, 1'b0);
        // Flush any dropout count left by the random tail
        sense.low_feedback = 1'b0;
        step(PUMP_DIV + 1);
        sense.low_feedback = 1'b1;
        step(29 * PUMP_DIV);
        chk(ctl.pump_double, 1'b0);
        step(6 * PUMP_DIV);
        chk(ctl.pump_double, 1'b1);
        sense.low_feedback = 1'b0;
        step(50);
        chk(ctl.pump_double, 1'b1);
        for (int i = 0; i < 2; i++) begin
            sense.over_voltage = (i == 0);
            sense.over_current = (i == 1);
            step(1);
            chk(ctl.pump_enable, 1'b0);
            chk(ctl.pump_double, 1'b1);
            sense = '0;
            step(1);
            chk(ctl.pump_enable, 1'b1);
        end
        sel_req = 1'b1;
        step(1);
        sel_req = 1'b0;
        step(2);
        chk(ctl.pump_double, 1'b0);
        sense.low_feedback = 1'b1;
        step(34 * PUMP_DIV);
        sense.low_feedback = 1'b0;
        chk(ctl.pump_double, 1'b1);
        sense.thermal_trip = 1'b1;
        step(2);
        chk(ctl.pump_enable | ctl.pump_double, 1'b0);
        sense.thermal_trip = 1'b0;
        step(SS + 2);
        chk(ctl.pump_double, 1'b0);
        sel_req = 1'b1;
        step(1);
        chk(ctl.strobe_target, 1'b1);
        step(SC - 20);
        chk(ctl.strobe_timed_out, 1'b0);
        step(40);
        chk(ctl.strobe_timed_out & ~ctl.pump_enable, 1'b1);
        sel_req = 1'b0;
        step(2);
        chk(ctl.strobe_timed_out, 1'b0);
        sel_req = 1'b1;
        step(2);
        chk(ctl.pump_enable, 1'b1);
        en_req = 1'b0;
        step(2);
        chk(ctl.pump_enable | ctl.pump_double, 1'b0);
        final_report();
    end
endmodule // tb_top
